// *** core/rwc_sync.sv ***
// two-flop synchroniser bank with constant reset values
module rwc_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // levels in and out
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout
);

  logic [W-1:0] meta_q;  // first stage, read only by the second

  // plain double stage; reset takes constants only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

// *** core/rwc_top.sv ***
// reset sources, start-up delay, watchdog and their wishbone registers
// What this block does
// R1: watchdog overflow issues a device reset
// R2: key 10101 disables, 01010 enables, else reset
// R3: normal-mode timeout: full reset, timeout flag set
// R4: sleep timeout: flag, clear PC and SP only
// R5: illegal key, pin low, clear, halt clear counter
// R6: one single clear instruction clears the watchdog
// R7: timeout is slow clock over power of two
// R8: power-on reset clears program counter
// R9: power-on reset presets ports high as inputs
// R10: power-on and brownout wait 50 ms start-up
// R11: reset pin low resets, restart from zero
// R12: after pin release wait 16.7 ms
// R13: pin key 55 port, AA reset pin
// R14: all resets reload pin key except warm
// R15: brownout detection off in sleep or idle
// R16: qualified brownout resets after 2-3 slow ticks
// R17: brownout shorter than minimum time is ignored
// R18: brownout flag software-clearable, never software-set
// R19: unimplemented mode bits read as zero
// R20: normal timeout equals brownout reset plus flag
// R21: illegal key resets after 2-3 ticks, flags
// R22: period select 000..111 gives 2^8..2^15
// R23: key fault flag set by hardware, software clears
// R24: async sources synchronised, async assert, sync release; pin and brownout assert only after the double stage
// R25: disable code holds counter clear, enable counts
`include "rwc_cfg.svh"
module rwc_top #(
  parameter int POR_DLY_CYC = `RWC_T_START_POR_US * `RWC_CLK_MHZ,
  parameter int PIN_DLY_CYC = (`RWC_T_START_PIN_NS * `RWC_CLK_MHZ) / 1000,
  parameter int LVR_MIN_CYC = `RWC_BROWNOUT_MIN_DURATION_MIN_US * `RWC_CLK_MHZ
) (
  // clock and power-on reset
  input  wire logic                clk,
  input  wire logic                rst,
  // register bus
  input  wire rwc_pkg::rwc_wb_req_t wbReq,
  output rwc_pkg::rwc_wb_rsp_t     wbRsp,
  // external sources and core events
  input  wire logic                extResetPinN,
  input  wire logic                brownoutDetect,
  input  wire logic                slowOscTick,
  input  wire logic                lowPowerMode,
  input  wire logic                watchdogClearInstr,
  input  wire logic                haltInstr,
  // reset controls to the core
  output rwc_pkg::rwc_ctl_t        ctl
);

  // watchdog limit for a period select code
  function automatic logic [15:0] wdtLimit(input logic [2:0] sel);
    logic [4:0] e;
    e = 5'(`RWC_WDT_MIN_EXP) + 5'(sel);
    wdtLimit = 16'((17'h00001 << e) - 17'h00001);
  endfunction

  // synchronised levels
  logic [2:0] syncOut;               // {por hold, pin, brownout}
  logic       porHold;               // power-on hold, released synchronously
  logic       pinN;                  // reset pin level
  logic       lowV;                  // brownout comparator level

  // registers
  rwc_pkg::rwc_state_t state_q, state_d;  // sequencer
  logic [22:0] dlyCnt_q;             // start-up countdown
  logic        longDly_q;            // 50 ms delay chosen for this hold
  logic [7:0]  wdtCtrl_q;            // watchdog control register
  logic [7:0]  pinKey_q;             // pin function key register
  logic        sysKeep_q;            // idle system clock keep
  logic        d3_q;                 // reserved read/write bit
  logic        bfFlag_q;             // brownout reset flag
  logic        kfFlag_q;             // key fault reset flag
  logic        toFlag_q;             // timeout flag
  logic [15:0] wdtCnt_q;             // watchdog counter
  logic [23:0] lvCnt_q;              // brownout qualification time
  logic [1:0]  lvTicks_q;            // slow ticks since qualification
  logic        kfPend_q;             // illegal key waiting to fire
  logic [1:0]  kfTicks_q;            // slow ticks since illegal key
  logic        ack_q;                // bus answer
  logic [31:0] rdDat_q;              // read data latch
  logic        fullRst_q;            // core held in reset
  logic        pcSp_q;               // program counter and stack clear
  logic        warm_q;               // warm reset pulse
  logic        pinHeld_q;            // pin still low; the hold reloads the key, so remember it

  // R24 all level sources pass a double stage; por hold asserts with rst
  rwc_sync #(
    .W       (3),
    .RST_VAL (3'h6)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({1'b0, extResetPinN, brownoutDetect}),
    .dout (syncOut)
  );
  assign porHold = syncOut[2];  // R24
  assign pinN    = syncOut[1];
  assign lowV    = syncOut[0];

  // bus decode
  wire busReq    = wbReq.cyc & wbReq.stb;
  wire wrLane    = busReq & wbReq.we & wbReq.sel[0] & ack_q;
  wire selWdt    = wbReq.adr == `RWC_OFS_WDT_CTRL;
  wire selPin    = wbReq.adr == `RWC_OFS_PIN_KEY;
  wire selSm     = wbReq.adr == `RWC_OFS_SYSTEM_MODE_FLAGS_1;
  wire selSt     = wbReq.adr == `RWC_OFS_STATUS;
  wire running   = state_q == rwc_pkg::RWC_ST_RUN;
  wire holding   = state_q == rwc_pkg::RWC_ST_HOLD;
  wire wrWdt     = wrLane & selWdt & running;
  wire wrPin     = wrLane & selPin & running;
  wire wrSm      = wrLane & selSm & running;
  wire [4:0] wrKey = wbReq.dat[`RWC_WDT_KEY_MSB:`RWC_WDT_KEY_LSB];

  // key decoding
  wire [4:0] wdtKey  = wdtCtrl_q[`RWC_WDT_KEY_MSB:`RWC_WDT_KEY_LSB];
  wire [2:0] wdtSel  = wdtCtrl_q[`RWC_WDT_SEL_MSB:`RWC_WDT_SEL_LSB];
  wire wdtEnabled    = wdtKey == `RWC_WDT_KEY_EN;  // R2
  wire keyIllegal    = (wrKey != `RWC_WDT_KEY_EN) && (wrKey != `RWC_WDT_KEY_DIS);
  wire kfWrite       = wrWdt & keyIllegal;  // R2
  wire pinIsReset    = pinKey_q == `RWC_PIN_KEY_RESET;  // R13
  wire pinRstAct     = pinIsReset & ~pinN;  // R11

  // brownout qualification; ignored while asleep
  wire lvArm   = lowV & ~lowPowerMode;  // R15
  wire lvQual  = lvCnt_q == 24'(LVR_MIN_CYC);  // R17
  wire lvrFire = lvQual & slowOscTick & (lvTicks_q == `RWC_SLOW_INTERNAL_OSCILLATOR_FIRE_TICK);  // R16
  wire lvHold  = lvQual & (lvTicks_q > `RWC_SLOW_INTERNAL_OSCILLATOR_FIRE_TICK);

  // key fault fires on the second slow tick
  wire kfFire  = kfPend_q & slowOscTick & (kfTicks_q == `RWC_SLOW_INTERNAL_OSCILLATOR_FIRE_TICK);  // R21

  // watchdog overflow and its two flavours
  wire wdtClr      = kfWrite | pinRstAct | watchdogClearInstr | haltInstr | ~running | ~wdtEnabled;  // R5
  wire wdtFire     = running & wdtEnabled & slowOscTick & (wdtCnt_q == wdtLimit(wdtSel));  // R7
  wire wdtNormFire = wdtFire & ~lowPowerMode;  // R3
  wire wdtWarmFire = wdtFire & lowPowerMode;   // R4

  // reset sources
  wire holdSrc = porHold | pinRstAct | (pinHeld_q & ~pinN) | lvHold;  // R11
  wire longSrc = porHold | lvHold | lvrFire | kfFire | wdtNormFire;  // R10
  wire anySrc  = holdSrc | lvrFire | kfFire | wdtNormFire;  // R1

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      rwc_pkg::RWC_ST_HOLD: begin
        // stay while a level source persists
        if (!holdSrc) begin
          state_d = rwc_pkg::RWC_ST_DELAY;
        end
      end
      rwc_pkg::RWC_ST_DELAY: begin
        // a new source restarts the hold
        if (anySrc) begin
          state_d = rwc_pkg::RWC_ST_HOLD;
        end else if (dlyCnt_q == 23'h000001) begin
          state_d = rwc_pkg::RWC_ST_RUN;
        end
      end
      rwc_pkg::RWC_ST_RUN: begin
        if (anySrc) begin
          state_d = rwc_pkg::RWC_ST_HOLD;  // R1
        end
      end
      default: state_d = rwc_pkg::RWC_ST_HOLD;
    endcase
  end

  // sequencer and start-up countdown
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q   <= rwc_pkg::RWC_ST_HOLD;
      longDly_q <= 1'b1;
      dlyCnt_q  <= 23'h000000;
    end else begin
      state_q <= state_d;
      if (state_q != rwc_pkg::RWC_ST_HOLD && state_d == rwc_pkg::RWC_ST_HOLD) begin
        longDly_q <= longSrc;  // R10
      end else if (holding && longSrc) begin
        longDly_q <= 1'b1;
      end
      if (holding) begin
        // long wait after power or brownout, short after the pin
        dlyCnt_q <= (longDly_q | longSrc) ? 23'(POR_DLY_CYC) : 23'(PIN_DLY_CYC);  // R12
      end else if (dlyCnt_q != 23'h000000) begin
        dlyCnt_q <= dlyCnt_q - 23'h000001;
      end
    end
  end

  // core reset outputs come from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fullRst_q <= 1'b1;
      pcSp_q    <= 1'b1;
      warm_q    <= 1'b0;
      pinHeld_q <= 1'b0;
    end else begin
      // pin reset lasts until the pin is high, key reload or not
      pinHeld_q <= pinRstAct | (pinHeld_q & ~pinN);  // R12
      fullRst_q <= state_d != rwc_pkg::RWC_ST_RUN;  // R11
      pcSp_q    <= (state_d != rwc_pkg::RWC_ST_RUN) | wdtWarmFire;  // R8
      warm_q    <= wdtWarmFire;  // R4
    end
  end

  // watchdog counter on the slow tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdtCnt_q <= 16'h0000;
    end else if (wdtClr || wdtFire) begin
      wdtCnt_q <= 16'h0000;  // R25
    end else if (slowOscTick) begin
      wdtCnt_q <= wdtCnt_q + 16'h0001;  // R22
    end
  end

  // brownout qualification and tick count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lvCnt_q   <= 24'h000000;
      lvTicks_q <= 2'h0;
    end else begin
      if (!lvArm) begin
        lvCnt_q <= 24'h000000;  // R17
      end else if (!lvQual) begin
        lvCnt_q <= lvCnt_q + 24'h000001;
      end
      if (!lvQual || !lvArm) begin
        lvTicks_q <= 2'h0;
      end else if (slowOscTick && lvTicks_q != 2'h3) begin
        lvTicks_q <= lvTicks_q + 2'h1;
      end
    end
  end

  // illegal key waits two slow ticks before resetting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      kfPend_q  <= 1'b0;
      kfTicks_q <= 2'h0;
    end else if (kfWrite) begin
      kfPend_q  <= 1'b1;  // R21
      kfTicks_q <= 2'h0;
    end else if (kfFire || holding) begin
      kfPend_q  <= 1'b0;
      kfTicks_q <= 2'h0;
    end else if (kfPend_q && slowOscTick) begin
      kfTicks_q <= kfTicks_q + 2'h1;
    end
  end

  // control registers: reloaded by every full reset, not by warm
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdtCtrl_q <= `RWC_WDT_CTRL_RST;
      pinKey_q  <= `RWC_PIN_KEY_RST;
      sysKeep_q <= 1'b0;
      d3_q      <= 1'b0;
    end else if (holding) begin
      wdtCtrl_q <= `RWC_WDT_CTRL_RST;
      pinKey_q  <= `RWC_PIN_KEY_RST;  // R14
      sysKeep_q <= 1'b0;
      d3_q      <= 1'b0;
    end else begin
      if (wrWdt) begin
        wdtCtrl_q <= wbReq.dat[7:0];  // R2
      end
      if (wrPin) begin
        pinKey_q <= wbReq.dat[7:0];  // R13
      end
      if (wrSm) begin
        sysKeep_q <= wbReq.dat[`RWC_SM_SYSKEEP];
        d3_q      <= wbReq.dat[`RWC_SM_D3];
      end
    end
  end

  // reset cause flags survive every reset but power-on; set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bfFlag_q <= 1'b0;
      kfFlag_q <= 1'b0;
      toFlag_q <= 1'b0;
    end else begin
      if (lvrFire) begin
        bfFlag_q <= 1'b1;  // R16
      end else if (wrSm && !wbReq.dat[`RWC_SM_BROWNOUT]) begin
        bfFlag_q <= 1'b0;  // R18
      end
      if (kfFire) begin
        kfFlag_q <= 1'b1;  // R23
      end else if (wrSm && !wbReq.dat[`RWC_SM_KEYFAULT]) begin
        kfFlag_q <= 1'b0;  // R23
      end
      if (wdtFire) begin
        toFlag_q <= 1'b1;  // R20
      end else if (watchdogClearInstr || haltInstr) begin
        toFlag_q <= 1'b0;  // R6
      end
    end
  end

  // read mux; unimplemented bits stay zero
  wire [7:0] smRead = {sysKeep_q, 3'h0, d3_q, bfFlag_q, 1'b0, kfFlag_q};  // R19
  wire [7:0] stRead = {4'h0, running, pinIsReset, wdtEnabled, toFlag_q};
  wire [7:0] rdMux  = selWdt ? wdtCtrl_q :
                      selPin ? pinKey_q :
                      selSm  ? smRead :
                      selSt  ? stRead : 8'h00;

  // one-cycle answer, dropped the cycle after; unmapped reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdDat_q <= 32'h00000000;
    end else begin
      ack_q <= busReq & ~ack_q;
      if (busReq && !ack_q) begin
        rdDat_q <= {24'h000000, rdMux};
      end
    end
  end

  assign wbRsp.ack = ack_q;
  assign wbRsp.dat = rdDat_q;

  // outputs to the core
  assign ctl.fullReset        = fullRst_q;
  assign ctl.pcSpClear        = pcSp_q;
  assign ctl.portPreset       = fullRst_q;  // R9
  assign ctl.timeoutFlag      = toFlag_q;
  assign ctl.pinIsReset       = pinKey_q == `RWC_PIN_KEY_RESET;
  assign ctl.idleSysclockKeep = sysKeep_q;

  // checks on the logic above
  sequence s_kfArmed;
    kfPend_q && slowOscTick && kfTicks_q == 2'h1;
  endsequence

  sequence s_heldThenDelay;
    holding ##1 (state_q == rwc_pkg::RWC_ST_DELAY);
  endsequence

  property p_wdtFullReset;
    @(posedge clk) disable iff (rst) wdtNormFire |=> holding && toFlag_q;
  endproperty
  a_wdtFullReset: assert property (p_wdtFullReset) else $error("normal timeout did not reset");  // R3

  property p_wdtWarm;
    @(posedge clk) disable iff (rst) wdtWarmFire |=> running && warm_q && ctl.pcSpClear && !ctl.fullReset;
  endproperty
  a_wdtWarm: assert property (p_wdtWarm) else $error("sleep timeout not a warm reset");  // R4

  property p_warmKeepsKey;
    @(posedge clk) disable iff (rst) wdtWarmFire |=> $stable(pinKey_q) && $stable(wdtCtrl_q);
  endproperty
  a_warmKeepsKey: assert property (p_warmKeepsKey) else $error("warm reset touched keys");  // R14

  property p_badKeyClears;
    @(posedge clk) disable iff (rst) kfWrite |=> wdtCnt_q == 16'h0000 && kfPend_q;
  endproperty
  a_badKeyClears: assert property (p_badKeyClears) else $error("illegal key did not clear");  // R5

  property p_kfReset;
    @(posedge clk) disable iff (rst) s_kfArmed |=> holding && kfFlag_q;
  endproperty
  a_kfReset: assert property (p_kfReset) else $error("key fault reset missing");  // R21

  property p_disabledIdle;
    @(posedge clk) disable iff (rst) (wdtKey == `RWC_WDT_KEY_DIS) [*2] |-> wdtCnt_q == 16'h0000;
  endproperty
  a_disabledIdle: assert property (p_disabledIdle) else $error("disabled watchdog counted");  // R25

  property p_sleepNoLvr;
    @(posedge clk) disable iff (rst) lowPowerMode |=> lvCnt_q == 24'h000000 && !lvrFire;
  endproperty
  a_sleepNoLvr: assert property (p_sleepNoLvr) else $error("brownout armed in sleep");  // R15

  property p_lvrFlag;
    @(posedge clk) disable iff (rst) lvrFire |=> bfFlag_q && holding;
  endproperty
  a_lvrFlag: assert property (p_lvrFlag) else $error("brownout reset missing");  // R16

  property p_flagNoSwSet;
    @(posedge clk) disable iff (rst) wrSm && !bfFlag_q && !lvrFire |=> !bfFlag_q;
  endproperty
  a_flagNoSwSet: assert property (p_flagNoSwSet) else $error("software set brownout flag");  // R18

  property p_reservedZero;
    @(posedge clk) disable iff (rst) busReq && !ack_q && selSm |=> wbRsp.dat[6:4] == 3'h0 && !wbRsp.dat[1];
  endproperty
  a_reservedZero: assert property (p_reservedZero) else $error("unimplemented bits not zero");  // R19

  property p_pinDelay;
    @(posedge clk) disable iff (rst) !longDly_q ##0 s_heldThenDelay |-> dlyCnt_q == 23'(PIN_DLY_CYC);
  endproperty
  a_pinDelay: assert property (p_pinDelay) else $error("pin start-up delay wrong");  // R12

endmodule

// *** shared/rwc_cfg.svh ***
// offsets, field positions, reset values, key codes and timing figures of the reset and watchdog control
`ifndef RWC_CFG_SVH
`define RWC_CFG_SVH

// register byte offsets on the bus
`define RWC_OFS_WDT_CTRL   8'h00
`define RWC_OFS_PIN_KEY    8'h04
`define RWC_OFS_SYSTEM_MODE_FLAGS_1      8'h08
`define RWC_OFS_STATUS     8'h0C

// watchdog control fields
`define RWC_WDT_KEY_MSB    7
`define RWC_WDT_KEY_LSB    3
`define RWC_WDT_SEL_MSB    2
`define RWC_WDT_SEL_LSB    0
`define RWC_WDT_KEY_DIS    5'h15
`define RWC_WDT_KEY_EN     5'h0A
`define RWC_WDT_CTRL_RST   8'h53
`define RWC_WDT_MIN_EXP    4'h8

// pin function key codes
`define RWC_PIN_KEY_PORT   8'h55
`define RWC_PIN_KEY_RESET  8'hAA
`define RWC_PIN_KEY_RST    8'h55

// system mode 1 fields
`define RWC_SM_SYSKEEP     7
`define RWC_SM_D3          3
`define RWC_SM_BROWNOUT    2
`define RWC_SM_KEYFAULT    0

// status fields
`define RWC_ST_TIMEOUT     0
`define RWC_ST_WDT_EN      1
`define RWC_ST_PIN_RESET   2
`define RWC_ST_RUNNING     3

// timing: clock rate in MHz, times in microseconds or nanoseconds
`define RWC_CLK_MHZ        100
`define RWC_T_START_POR_US 50000
`define RWC_T_START_PIN_NS 16700000
`define RWC_BROWNOUT_MIN_DURATION_MIN_US   120
`define RWC_SLOW_INTERNAL_OSCILLATOR_FIRE_TICK 2'h1

`endif

// *** shared/rwc_pkg.sv ***
// types shared by the reset and watchdog control
package rwc_pkg;

  // reset sequencer states, one-hot
  typedef enum logic [2:0] {
    RWC_ST_HOLD  = 3'b001,
    RWC_ST_DELAY = 3'b010,
    RWC_ST_RUN   = 3'b100
  } rwc_state_t;

  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } rwc_wb_req_t;

  // classic wishbone answer to the master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } rwc_wb_rsp_t;

  // reset controls toward the core
  typedef struct packed {
    logic fullReset;
    logic pcSpClear;
    logic portPreset;
    logic timeoutFlag;
    logic pinIsReset;
    logic idleSysclockKeep;
  } rwc_ctl_t;

endpackage

// *** testbench/rwc_ext_model.sv ***
// external reset network, supply monitor and slow oscillator seen at the pins
module rwc_ext_model #(
  parameter int TICK_DIV = 4
) (
  // fast clock
  input  wire logic clk,
  // scenario controls
  input  wire logic tickEn,
  input  wire logic pinLow,
  input  wire logic supplyLow,
  // pins toward the block
  output logic      extResetPinN,
  output logic      brownoutDetect,
  output logic      slowOscTick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] divQ = 8'h00;  // slow oscillator phase

  // pin has a pull-up: released means high, never a stale level
  assign extResetPinN = ~pinLow;
  // comparator follows the supply level directly
  assign brownoutDetect = supplyLow;
  // slow clock stands still when disabled, so bench can count ticks exactly
  assign slowOscTick = tickEn && (divQ == 8'(TICK_DIV - 1));

  // divider of the fast clock, restarts whenever the oscillator is stopped
  always_ff @(posedge clk) begin
    divQ <= (!tickEn || slowOscTick) ? 8'h00 : divQ + 8'h01;
  end
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench of the reset and watchdog control
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POR_D = 20;  // shortened start-up delays
  localparam int PIN_D = 12;
  localparam int LVR_M = 4;
  logic                 clk, rst, lowPowerMode, clrInstr, haltInstr;
  logic                 extResetPinN, brownoutDetect, slowOscTick;
  logic                 tickEn, pinLow, supplyLow;  // partner controls
  rwc_pkg::rwc_wb_req_t wbReq;
  rwc_pkg::rwc_wb_rsp_t wbRsp;
  rwc_pkg::rwc_ctl_t    ctl;
  int                   n_fail = 0, cmp_count = 0, tickCnt = 0, cycCnt = 0, nWait, t0;
  logic [7:0]           rd;  // last read data
  typedef struct {logic we; logic [7:0] adr; logic [7:0] dat;} rwc_row_t;
  // register rows: reads carry the expected value
  rwc_row_t rows [15] = '{
    '{1'b0, 8'h00, 8'h53}, '{1'b0, 8'h04, 8'h55}, '{1'b0, 8'h08, 8'h00}, '{1'b0, 8'h0C, 8'h0A},
    '{1'b0, 8'h10, 8'h00}, '{1'b1, 8'h08, 8'hFF}, '{1'b0, 8'h08, 8'h88}, '{1'b1, 8'h08, 8'h00},
    '{1'b0, 8'h08, 8'h00}, '{1'b1, 8'h04, 8'hAA}, '{1'b0, 8'h0C, 8'h0E}, '{1'b1, 8'h10, 8'hFF},
    '{1'b0, 8'h10, 8'h00}, '{1'b1, 8'h00, 8'hA8}, '{1'b0, 8'h0C, 8'h0C}};

  rwc_top #(.POR_DLY_CYC(POR_D), .PIN_DLY_CYC(PIN_D), .LVR_MIN_CYC(LVR_M)) rwc_top_inst (
    .clk(clk), .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp), .extResetPinN(extResetPinN),
    .brownoutDetect(brownoutDetect), .slowOscTick(slowOscTick), .lowPowerMode(lowPowerMode),
    .watchdogClearInstr(clrInstr), .haltInstr(haltInstr), .ctl(ctl));
  rwc_ext_model #(.TICK_DIV(4)) rwc_ext_model_inst (
    .clk(clk), .tickEn(tickEn), .pinLow(pinLow), .supplyLow(supplyLow),
    .extResetPinN(extResetPinN), .brownoutDetect(brownoutDetect), .slowOscTick(slowOscTick));

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ticks seen while the core runs, and the hang guard
  always @(posedge clk) begin
    cycCnt <= cycCnt + 1;
    if (ctl.fullReset === 1'b0 && slowOscTick === 1'b1) tickCnt <= tickCnt + 1;
    if (cycCnt == 30000) begin
      n_fail++;
      print_verdict();
    end
  end

  // counts and the single closing point
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // classic single wishbone cycle, held until ack is sampled
  task wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: {24'h0, wd}};
    do begin @(posedge clk); k++; end while (wbRsp.ack !== 1'b1 && k < 50);
    rd = wbRsp.dat[7:0];
    wbReq <= '0;
    `CHK("ack", 1'b1, k < 50)
  endtask

  // wait for fullReset (sel 0) or pcSpClear (sel 1) to reach a level
  task wait_sig(input logic sel, input logic v);
    nWait = 0;
    do begin @(posedge clk); nWait++; end while (((sel ? ctl.pcSpClear : ctl.fullReset) !== v) && nWait < 3000);
    `CHK("wait", 1'b1, nWait < 3000)
  endtask

  // one-cycle instruction pulse: 0 clear, 1 halt
  task pulse(input logic which);
    @(posedge clk);
    if (which) haltInstr <= 1'b1;
    else clrInstr <= 1'b1;
    @(posedge clk);
    haltInstr <= 1'b0;
    clrInstr <= 1'b0;
  endtask

  // let the slow oscillator run for n fast cycles
  task run(input int n);
    tickEn <= 1'b1;
    repeat (n) @(posedge clk);
    tickEn <= 1'b0;
  endtask

  // start ticks and count them until the chosen output rises
  task count_to(input logic sel);
    t0 = tickCnt;
    tickEn <= 1'b1;
    wait_sig(sel, 1'b1);
    tickEn <= 1'b0;
  endtask

  initial begin
    rst = 1'b1; wbReq = '0; lowPowerMode = 1'b0; clrInstr = 1'b0; haltInstr = 1'b0;
    tickEn = 1'b0; pinLow = 1'b0; supplyLow = 1'b0;
    repeat (20) @(posedge clk);
    `CHK("pc clear", 1'b1, ctl.pcSpClear)
    `CHK("port preset", 1'b1, ctl.portPreset)
    rst <= 1'b0;
    wait_sig(1'b0, 1'b0);
    `CHK("por delay", 1'b1, nWait >= POR_D && nWait <= POR_D + 5)
    $display("test power-on done");
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].adr, rows[i].dat);
      if (!rows[i].we) `CHK("reg", rows[i].dat, rd)
    end
    $display("test registers done");
    // enable, period 2^8; clear and halt must each restart the count
    wb(1'b1, 8'h00, 8'h50);
    run(800);
    pulse(1'b0);
    run(800);
    `CHK("clear holds off timeout", 1'b0, ctl.timeoutFlag)
    pulse(1'b1);
    `CHK("no early reset", 1'b0, ctl.fullReset)
    count_to(1'b0);
    `CHK("ticks to overflow", 256, tickCnt - t0)
    `CHK("timeout flag", 1'b1, ctl.timeoutFlag)
    wait_sig(1'b0, 1'b0);
    wb(1'b0, 8'h04, 8'h00);
    `CHK("pin key reload", 8'h55, rd)
    $display("test watchdog normal done");
    // sleep timeout at period 2^9 touches only pc and stack
    wb(1'b1, 8'h04, 8'hAA);
    wb(1'b1, 8'h00, 8'h51);
    lowPowerMode <= 1'b1;
    count_to(1'b1);
    `CHK("sleep ticks", 512, tickCnt - t0)
    `CHK("sleep no full reset", 1'b0, ctl.fullReset)
    @(posedge clk);
    `CHK("pc pulse ends", 1'b0, ctl.pcSpClear)
    wb(1'b0, 8'h04, 8'h00);
    `CHK("pin key kept", 8'hAA, rd)
    `CHK("pin is reset", 1'b1, ctl.pinIsReset)
    wb(1'b1, 8'h00, 8'hA8);
    supplyLow <= 1'b1;
    run(100);
    supplyLow <= 1'b0;
    `CHK("brownout off in sleep", 1'b0, ctl.fullReset)
    lowPowerMode <= 1'b0;
    $display("test watchdog sleep done");
    // brownout: short glitch ignored, long one resets and flags
    @(posedge clk);
    supplyLow <= 1'b1;
    repeat (2) @(posedge clk);
    supplyLow <= 1'b0;
    run(60);
    `CHK("short brownout", 1'b0, ctl.fullReset)
    @(posedge clk);
    supplyLow <= 1'b1;
    tickEn <= 1'b1;
    wait_sig(1'b0, 1'b1);
    `CHK("brownout latency", 1'b1, nWait >= LVR_M + 2 && nWait <= LVR_M + 16)
    supplyLow <= 1'b0;
    tickEn <= 1'b0;
    wait_sig(1'b0, 1'b0);
    wb(1'b0, 8'h08, 8'h00);
    `CHK("brownout flag", 8'h04, rd)
    $display("test brownout done");
    // illegal key: reset on the second slow tick, fault flag set
    wb(1'b1, 8'h00, 8'hF8);
    count_to(1'b0);
    `CHK("key fault ticks", 2, tickCnt - t0)
    wait_sig(1'b0, 1'b0);
    wb(1'b0, 8'h08, 8'h00);
    `CHK("both flags", 8'h05, rd)
    wb(1'b1, 8'h08, 8'h80);
    wb(1'b0, 8'h08, 8'h00);
    `CHK("flags cleared", 8'h80, rd)
    `CHK("sysclock keep", 1'b1, ctl.idleSysclockKeep)
    $display("test key fault done");
    // pin ignored as port pin, acts as reset pin after key AA
    pinLow <= 1'b1;
    repeat (30) @(posedge clk);
    `CHK("pin as port", 1'b0, ctl.fullReset)
    pinLow <= 1'b0;
    wb(1'b1, 8'h04, 8'hAA);
    pinLow <= 1'b1;
    wait_sig(1'b0, 1'b1);
    `CHK("pin pc clear", 1'b1, ctl.pcSpClear)
    repeat (10) @(posedge clk);
    pinLow <= 1'b0;
    wait_sig(1'b0, 1'b0);
    `CHK("pin delay", 1'b1, nWait >= PIN_D && nWait <= PIN_D + 5)
    wb(1'b0, 8'h04, 8'h00);
    `CHK("pin key after pin reset", 8'h55, rd)
    `CHK("keep reloaded", 1'b0, ctl.idleSysclockKeep)
    $display("test reset pin done");
    // power-on again in mid-run: timeout flag and delay start afresh
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("por pc clear again", 1'b1, ctl.pcSpClear)
    rst <= 1'b0;
    wait_sig(1'b0, 1'b0);
    `CHK("por delay again", 1'b1, nWait >= POR_D && nWait <= POR_D + 5)
    `CHK("por clears timeout", 1'b0, ctl.timeoutFlag)
    $display("test power-on again done");
    print_verdict();
  end
endmodule
